// >>> core/i2c_flags.sv
// holds the bus status flags, address mask comparator and register port
// assumes engine events are one-cycle pulses synchronous to sys_clk
//
// Operation
// - stop-seen flag sets on stop and clears on start or repeated start.
// - start-seen flag sets on start or repeated start and clears on stop.
// - after a slave address byte the direction flag takes one for read, zero for write.
// - rx holding full sets when a received byte is loaded into the rx holding register.
// - reading the rx holding register clears rx holding full.
// - writing the tx holding register sets tx holding full.
// - tx holding full clears when shifting out of the byte completes.
// - address positions whose mask bit is one are ignored in matching.
// - address positions whose mask bit is zero must equal the programmed address.
// - mask upper six bits read zero and the ten mask bits reset to zero.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module i2c_flags
	import flags_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire reg_req_t req,
	output logic [15:0] rdata,
	input wire link_ev_t ev,
	input wire logic [9:0] rx_addr,
	input wire logic addr_10bit,
	output logic addr_match,
	output logic [7:0] tx_byte,
	output logic tx_load,
	output logic irq
);
	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (ADDR_W != 10) begin : g_chk
		$error("ADDR_W must be 10");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic stop_r, stop_nxt, start_r, start_nxt, dir_r, dir_nxt;
	logic rxf_r, rxf_nxt, txf_r, txf_nxt;
	logic [ADDR_W-1:0] mask_r, mask_nxt, addr_r, addr_nxt;
	logic [7:0] rxh_r, rxh_nxt, txh_r, txh_nxt;
	logic [EV_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt, evv;
	logic [15:0] rdata_nxt;
	logic match_nxt, match_r, tx_load_nxt, tx_load_r, irq_nxt, irq_r;
	logic [ADDR_W-1:0] cmp_diff;

	// ----------------------------------------
	// address comparator
	// ----------------------------------------
	// masked compare; seven-bit uses low bits with upper forced equal
	always_comb begin
		cmp_diff = (rx_addr ^ addr_r) & ~mask_r;
		if (!addr_10bit) begin
			cmp_diff[9:7] = 3'h0;
		end
		match_nxt = ev.addr_done && (cmp_diff == 10'h000);
	end

	// ----------------------------------------
	// flag and register next values
	// ----------------------------------------
	// next values of flags and registers
	always_comb begin
		stop_nxt = stop_r;
		start_nxt = start_r;
		dir_nxt = dir_r;
		rxf_nxt = rxf_r;
		txf_nxt = txf_r;
		mask_nxt = mask_r;
		addr_nxt = addr_r;
		rxh_nxt = rxh_r;
		txh_nxt = txh_r;
		ien_nxt = ien_r;
		tx_load_nxt = 1'b0;
		if (ev.stop_det) begin
			stop_nxt = 1'b1;
			start_nxt = 1'b0;
		end
		if (ev.start_det) begin
			stop_nxt = 1'b0;
			start_nxt = 1'b1;
		end
		if (ev.addr_done) begin
			dir_nxt = ev.addr_read;
		end
		// software read clear first so a same-cycle load wins
		if (req.rd && req.addr == RX_OFS) begin
			rxf_nxt = 1'b0;
		end
		if (ev.rx_load) begin
			rxf_nxt = 1'b1;
			rxh_nxt = ev.rx_byte;
		end
		if (ev.tx_done) begin
			txf_nxt = 1'b0;
		end
		if (req.wr) begin
			case (req.addr)
				MASK_OFS: mask_nxt = req.wdata[9:0];
				ADDR_OFS: addr_nxt = req.wdata[9:0];
				TX_OFS: begin
					txh_nxt = req.wdata[7:0];
					txf_nxt = 1'b1;
					tx_load_nxt = 1'b1;
				end
				IRQ_EN_OFS: ien_nxt = req.wdata[EV_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	// sticky events: set wins over write-one clear
	always_comb begin
		evv = '0;
		evv[EV_START] = ev.start_det;
		evv[EV_STOP] = ev.stop_det;
		evv[EV_RX] = ev.rx_load;
		evv[EV_TXDONE] = ev.tx_done;
		evv[EV_MATCH] = match_nxt;
		ist_nxt = ist_r;
		if (req.wr && req.addr == IRQ_ST_OFS) begin
			ist_nxt = ist_r & ~req.wdata[EV_W-1:0];
		end
		ist_nxt = ist_nxt | evv;
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	// read mux; unmapped and unimplemented bits read zero
	always_comb begin
		rdata_nxt = ZERO16;
		if (req.rd) begin
			case (req.addr)
				STATUS_OFS: begin
					rdata_nxt[STOP_BIT] = stop_r;
					rdata_nxt[START_BIT] = start_r;
					rdata_nxt[DIR_BIT] = dir_r;
					rdata_nxt[RXF_BIT] = rxf_r;
					rdata_nxt[TXF_BIT] = txf_r;
				end
				MASK_OFS: rdata_nxt[9:0] = mask_r;
				ADDR_OFS: rdata_nxt[9:0] = addr_r;
				RX_OFS: rdata_nxt[7:0] = rxh_r;
				TX_OFS: rdata_nxt[7:0] = txh_r;
				IRQ_ST_OFS: rdata_nxt[EV_W-1:0] = ist_r;
				IRQ_EN_OFS: rdata_nxt[EV_W-1:0] = ien_r;
				default: rdata_nxt = ZERO16;
			endcase
		end
	end

	// ----------------------------------------
	// bus condition and buffer flags
	// ----------------------------------------
	// flags drop to zero on reset; the engine must not pulse during it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stop_r <= 1'b0;
			start_r <= 1'b0;
			dir_r <= 1'b0;
			rxf_r <= 1'b0;
			txf_r <= 1'b0;
		end else begin
			stop_r <= stop_nxt;
			start_r <= start_nxt;
			dir_r <= dir_nxt;
			rxf_r <= rxf_nxt;
			txf_r <= txf_nxt;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// mask, own address, holding bytes and enable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_r <= MASK_RST;
			addr_r <= ADDR_RST;
			rxh_r <= 8'h00;
			txh_r <= 8'h00;
			ien_r <= '0;
			tx_load_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
			addr_r <= addr_nxt;
			rxh_r <= rxh_nxt;
			txh_r <= txh_nxt;
			ien_r <= ien_nxt;
			tx_load_r <= tx_load_nxt;
		end
	end

	// ----------------------------------------
	// interrupt and match outputs
	// ----------------------------------------
	// irq is registered from next values so it moves with the status bit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ist_r <= '0;
			match_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			ist_r <= ist_nxt;
			match_r <= match_nxt;
			irq_r <= irq_nxt;
		end
	end

	// read data flop; zero outside the cycle after a read strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata <= ZERO16;
		end else begin
			rdata <= rdata_nxt;
		end
	end

	// outputs straight from their flops
	assign addr_match = match_r;
	assign tx_load = tx_load_r;
	assign tx_byte = txh_r;
	assign irq = irq_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// bus condition and direction flags
	stop_sets_a: assert property (ev.stop_det && !ev.start_det |=> stop_r && !start_r)
		else $error("stop flag not set after stop");
	start_sets_a: assert property (ev.start_det |=> start_r && !stop_r)
		else $error("start flag not set after start");
	dir_update_a: assert property (ev.addr_done |=> dir_r == $past(ev.addr_read))
		else $error("direction flag wrong after address");
	dir_hold_a: assert property (!ev.addr_done |=> $stable(dir_r))
		else $error("direction flag moved without an address");
	status_read_a: assert property (req.rd && req.addr == STATUS_OFS |=>
		rdata == {11'h000, $past(stop_r), $past(start_r), $past(dir_r),
		$past(rxf_r), $past(txf_r)})
		else $error("status read does not show the flags");

	// buffer flags and holding registers
	rx_full_a: assert property (ev.rx_load |=> rxf_r && rxh_r == $past(ev.rx_byte))
		else $error("rx full not set on load");
	rx_clear_a: assert property (req.rd && req.addr == RX_OFS && !ev.rx_load |=> !rxf_r)
		else $error("rx full not cleared by read");
	rx_read_a: assert property (req.rd && req.addr == RX_OFS |=> rdata == {8'h00, $past(rxh_r)})
		else $error("rx holding read wrong");
	tx_full_a: assert property (req.wr && req.addr == TX_OFS |=> txf_r && tx_load)
		else $error("tx full not set on write");
	tx_clear_a: assert property (ev.tx_done && !(req.wr && req.addr == TX_OFS) |=> !txf_r)
		else $error("tx full not cleared on done");
	tx_byte_a: assert property (req.wr && req.addr == TX_OFS |=> tx_byte == $past(req.wdata[7:0]))
		else $error("tx byte not taken from write");
	tx_pulse_a: assert property (!(req.wr && req.addr == TX_OFS) |=> !tx_load)
		else $error("tx load without a write");

	// address comparator
	mask_ignore_a: assert property (ev.addr_done && addr_10bit
		&& (((rx_addr ^ addr_r) & ~mask_r) == 10'h000) |=> addr_match)
		else $error("masked address did not match");
	mask_require_a: assert property (ev.addr_done && addr_10bit
		&& (((rx_addr ^ addr_r) & ~mask_r) != 10'h000) |=> !addr_match)
		else $error("unmasked mismatch matched");
	seven_bit_a: assert property (ev.addr_done && !addr_10bit
		&& (((rx_addr[6:0] ^ addr_r[6:0]) & ~mask_r[6:0]) == 7'h00) |=> addr_match)
		else $error("seven bit match failed");
	match_pulse_a: assert property (!ev.addr_done |=> !addr_match)
		else $error("match without an address byte");
	mask_read_a: assert property (req.rd && req.addr == MASK_OFS |=> rdata[15:10] == 6'h00)
		else $error("mask upper bits not zero");
	mask_write_a: assert property (req.wr && req.addr == MASK_OFS |=> mask_r == $past(req.wdata[9:0]))
		else $error("mask not taken from write");

	// interrupt status and level
	irq_set_a: assert property (evv != '0 |=> (ist_r & $past(evv)) == $past(evv))
		else $error("event did not set its status bit");
	irq_clear_a: assert property (req.wr && req.addr == IRQ_ST_OFS && req.wdata[EV_START]
		&& !ev.start_det |=> !ist_r[EV_START])
		else $error("start status bit not cleared by write one");
	irq_level_a: assert property (##1 irq == |(ist_r & ien_r))
		else $error("irq does not follow status and enable");
	rdata_idle_a: assert property (!req.rd |=> rdata == ZERO16)
		else $error("read data not zero without a read");

	// main scenarios reached
	cv_start_c: cover property (ev.start_det ##[1:20] ev.stop_det);
	cv_rx_c: cover property (ev.rx_load ##[1:10] (req.rd && req.addr == RX_OFS));
	cv_tx_c: cover property ((req.wr && req.addr == TX_OFS) ##[1:30] ev.tx_done);
	cv_match_c: cover property (ev.addr_done && mask_r != 10'h000 ##1 addr_match);
	cv_seven_c: cover property (ev.addr_done && !addr_10bit ##1 addr_match);
endmodule : i2c_flags

// >>> pkg/flags_pkg.sv
// holds register offsets, field positions and reset values for the status/mask block
// assumes a 16-bit register port with word indices as addresses
package flags_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] STATUS_OFS = 4'h0;
	localparam logic [3:0] MASK_OFS = 4'h1;
	localparam logic [3:0] ADDR_OFS = 4'h2;
	localparam logic [3:0] RX_OFS = 4'h3;
	localparam logic [3:0] TX_OFS = 4'h4;
	localparam logic [3:0] IRQ_ST_OFS = 4'h5;
	localparam logic [3:0] IRQ_EN_OFS = 4'h6;
	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int STOP_BIT = 4;
	localparam int START_BIT = 3;
	localparam int DIR_BIT = 2;
	localparam int RXF_BIT = 1;
	localparam int TXF_BIT = 0;
	// ----------------------------------------
	// interrupt event positions and resets
	// ----------------------------------------
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_RX = 2;
	localparam int EV_TXDONE = 3;
	localparam int EV_MATCH = 4;
	localparam int EV_W = 5;
	localparam logic [9:0] MASK_RST = 10'h000;
	localparam logic [9:0] ADDR_RST = 10'h000;
	localparam logic [15:0] ZERO16 = 16'h0000;

	// events from the serial engine
	typedef struct packed {
		logic start_det;
		logic stop_det;
		logic addr_done;
		logic addr_read;
		logic rx_load;
		logic [7:0] rx_byte;
		logic tx_done;
	} link_ev_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage : flags_pkg

// >>> verification/bus_model.sv
// far-side model: serial engine pulses toward the flag block
// assumes its tasks are called from the bench just after a clock edge
`timescale 1ns/1ns
module bus_model
	import flags_pkg::*;
(
	input wire logic sys_clk,
	output link_ev_t ev,
	output logic [9:0] rx_addr,
	output logic addr_10bit
);
	// one-cycle event pulse, dropped right after the taking edge
	task automatic pulse(input link_ev_t e);
		@(posedge sys_clk);
		ev <= e;
		@(posedge sys_clk);
		ev <= '0;
	endtask : pulse
	// address byte; lines show the inverse afterwards so stale data never matches
	task automatic address(input logic [9:0] a, input logic ten, input logic rw);
		@(posedge sys_clk);
		ev <= '{1'b0, 1'b0, 1'b1, rw, 1'b0, 8'h00, 1'b0};
		rx_addr <= a;
		addr_10bit <= ten;
		@(posedge sys_clk);
		ev <= '0;
		rx_addr <= ~a;
	endtask : address
	initial begin
		ev = '0;
		rx_addr = 10'h000;
		addr_10bit = 1'b0;
	end
endmodule : bus_model

// >>> verification/test_i2c_flags.sv
// bench for the status flags, mask comparator and irq of i2c_flags
// assumes bus_model stands in for the serial engine
`timescale 1ns/1ns
module test_i2c_flags
	import flags_pkg::*;
;
	logic sys_clk;
	logic rst;
	reg_req_t req;
	logic [15:0] rdata;
	link_ev_t ev;
	logic [9:0] rx_addr;
	logic addr_10bit;
	logic addr_match;
	logic [7:0] tx_byte;
	logic tx_load;
	logic irq;
	int bad_count;
	int checks;

	i2c_flags dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata), .ev(ev),
		.rx_addr(rx_addr), .addr_10bit(addr_10bit), .addr_match(addr_match),
		.tx_byte(tx_byte), .tx_load(tx_load), .irq(irq));
	bus_model bus (.sys_clk(sys_clk), .ev(ev), .rx_addr(rx_addr), .addr_10bit(addr_10bit));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		req <= '0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		req <= '0;
		#1 chk(rdata, exp);
	endtask : rd
	task fire(input logic s, input logic p, input logic l, input logic [7:0] b, input logic t);
		bus.pulse('{s, p, 1'b0, 1'b0, l, b, t});
	endtask : fire
	task am(input logic [9:0] a, input logic ten, input logic exp);
		bus.address(a, ten, 1'b0);
		#1 chk({15'h0000, addr_match}, {15'h0000, exp});
	endtask : am
	task close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		req = '0;
		rst = 1'b1;
		bad_count = 0;
		checks = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(MASK_OFS, 16'h0000);
		wr(MASK_OFS, 16'hFFFF);
		rd(MASK_OFS, 16'h03FF);
		rd(4'hF, 16'h0000);
		$display("mask register test done");
		fire(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
		rd(STATUS_OFS, 16'h0008);
		fire(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		rd(STATUS_OFS, 16'h0010);
		fire(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
		rd(STATUS_OFS, 16'h0008);
		bus.address(10'h000, 1'b0, 1'b1);
		rd(STATUS_OFS, 16'h000C);
		bus.address(10'h000, 1'b0, 1'b0);
		rd(STATUS_OFS, 16'h0008);
		fire(1'b0, 1'b0, 1'b1, 8'hA5, 1'b0);
		rd(STATUS_OFS, 16'h000A);
		rd(RX_OFS, 16'h00A5);
		rd(STATUS_OFS, 16'h0008);
		wr(TX_OFS, 16'h005A);
		#1 chk({8'h00, tx_byte}, 16'h005A);
		chk({15'h0000, tx_load}, 16'h0001);
		@(posedge sys_clk);
		#1 chk({15'h0000, tx_load}, 16'h0000);
		rd(STATUS_OFS, 16'h0009);
		fire(1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
		rd(STATUS_OFS, 16'h0008);
		$display("status flag test done");
		// masked compare in both address widths
		wr(ADDR_OFS, 16'h02A5);
		wr(MASK_OFS, 16'h0000);
		am(10'h2A5, 1'b1, 1'b1);
		am(10'h2A4, 1'b1, 1'b0);
		wr(MASK_OFS, 16'h0201);
		am(10'h0A4, 1'b1, 1'b1);
		am(10'h0A6, 1'b1, 1'b0);
		am(10'h3A4, 1'b0, 1'b1);
		am(10'h3A6, 1'b0, 1'b0);
		$display("address match test done");
		// a mid-run reset must drop the programmed mask and every flag
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(MASK_OFS, 16'h0000);
		rd(STATUS_OFS, 16'h0000);
		$display("reset test done");
		// stop is masked, start is enabled
		wr(IRQ_ST_OFS, 16'h001F);
		wr(IRQ_EN_OFS, 16'h0001);
		fire(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		#1 chk({15'h0000, irq}, 16'h0000);
		fire(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
		#1 chk({15'h0000, irq}, 16'h0001);
		rd(IRQ_ST_OFS, 16'h0003);
		wr(IRQ_ST_OFS, 16'h0001);
		#1 chk({15'h0000, irq}, 16'h0000);
		$display("interrupt test done");
		close_out;
	end
	// watchdog well past the fewer than one hundred cycles the tests need
	initial begin
		#(4 * 3000);
		bad_count++;
		close_out;
	end
endmodule : test_i2c_flags
